//--- src/lbc_cfg.svh
`ifndef LBC_CFG_SVH
`define LBC_CFG_SVH

// Byte lane codes carried by a request
`define LANE_WORD 2'h0
`define LANE_EVEN 2'h1
`define LANE_ODD 2'h2
`define LANE_REFRESH 2'h3

// Bit positions inside the lane code: upper enable level, address bit 0
`define LANE_UPPER_BIT 0
`define LANE_A0_BIT 1

// Cycle kinds
`define KIND_READ 2'h0
`define KIND_WRITE 2'h1
`define KIND_REFRESH 2'h2

// Interrupt type raised on a coprocessor exception
`define FAULT_VECTOR 8'h10

// Idle level of the active-low strobes, and the transceiver direction levels
`define STROBE_IDLE 1'h1
`define DIR_RECEIVE 1'h0
`define DIR_TRANSMIT 1'h1

// Stages of the pin synchroniser
`define SYNC_STAGES 2

`endif

//--- src/lbc_pkg.sv
package lbc_pkg;

   typedef logic [1:0] lane_type;
   typedef logic [1:0] kind_type;

   // One bus cycle as the core asks for it
   typedef struct packed {
      kind_type kind;
      lane_type lane;
      logic coproc;
      logic locked;
      logic last;
      logic ignore_ready;
   } request_type;

   // Bus control pins, all active low except direction and addr0
   typedef struct packed {
      logic read_n;
      logic write_n;
      logic transceiver_enable_n;
      logic transceiver_direction;
      logic upper_byte_enable_n;
      logic addr0;
      logic refresh_indicator_n;
      logic coproc_select_n;
   } bus_pins_type;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_ADDR = 6'h02,
      ST_STROBE = 6'h04,
      ST_WAIT = 6'h08,
      ST_END = 6'h10,
      ST_GRANT = 6'h20
   } state_type;

endpackage

//--- src/pin_sync.sv
`timescale 1ns/1ps

// Two-stage synchroniser for asynchronous pins
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Pins in, synchronised levels out
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] meta;

   always_ff @(posedge clock) begin
      if (rst) begin
         meta <= INIT;
         level <= INIT;
      end else begin
         meta <= pin;
         level <= meta;
      end
   end

endmodule

//--- src/local_bus_ctrl.sv
`timescale 1ns/1ps
`include "lbc_cfg.svh"

// Functional notes
// RULE1: Upper byte enable and A0 encode word, even byte, odd byte, refresh.
// RULE2: On the narrow bus variant the refresh indicator goes low in refresh.
// RULE3: The read strobe is asserted in a read cycle so the target drives data.
// RULE4: The store strobe is asserted in a write cycle to write bus data.
// RULE5: A cycle ends only once ready is seen, unless told to ignore ready.
// RULE6: Transceiver enable is active only while data moves on the bus.
// RULE7: Transceiver direction follows the direction of the current transfer.
// RULE8: While the lock flag is active no bus request, hold included, is granted.
// RULE9: During reset the lock pin is an undriven input held weakly high.
// RULE10: Hold is granted only at an instruction boundary outside a lock.
// RULE11: On grant the bus grant output rises and bus outputs are floated.
// RULE12: Coprocessor select is active on coprocessor access, wide bus only.
// RULE13: Error is sampled at each numerics start and raises type 16 if active; with NARROW_BUS set the code never samples it or raises fault_irq.
// RULE14: Bus grant stays until hold is removed, then the bus is driven again.
module local_bus_ctrl #(
   parameter bit NARROW_BUS = 1'b0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Core request side
   input wire logic req_valid,
   input wire lbc_pkg::request_type req,
   output logic req_taken,
   output logic cycle_done,
   // Numerics operation start from the core
   input wire logic numerics_start,
   output logic fault_irq,
   output logic [7:0] fault_vector,
   // Asynchronous pins
   input wire logic ready,
   input wire logic hold,
   input wire logic error_n,
   // Bus control pins and their shared output enable
   output lbc_pkg::bus_pins_type pins,
   output logic pins_oe,
   // Lock pin, two-way
   input wire logic lock_in,
   output logic lock_out,
   output logic lock_oe,
   // Bus grant
   output logic bus_grant_out
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [2:0] pins_raw;
   logic [2:0] pins_sync;
   logic ready_s;
   logic hold_s;
   logic error_n_s;

   assign pins_raw = {ready, hold, error_n};

   pin_sync #(
      .WIDTH(3),
      .INIT(3'h1)
   ) u_sync (
      .clock(clock),
      .rst(rst),
      .pin(pins_raw),
      .level(pins_sync)
   );

   assign ready_s = pins_sync[2];
   assign hold_s = pins_sync[1];
   assign error_n_s = pins_sync[0];

   ////////////////////////////////////////////////////////////////////////
   // State and held request

   lbc_pkg::state_type state;
   lbc_pkg::state_type next_state;
   lbc_pkg::request_type cur;
   logic at_boundary;
   logic lock_active;

   wire is_idle = (state == lbc_pkg::ST_IDLE);
   wire lock_seen = lock_active;
   // Hold wins over a new request only at a boundary outside a lock
   wire grant_now = is_idle && hold_s && at_boundary
                    && !lock_seen; // see RULE8 see RULE10
   wire take_now = is_idle && req_valid && !grant_now;
   wire cycle_ok = ready_s || cur.ignore_ready; // see RULE5
   wire finish = (state == lbc_pkg::ST_END);

   always_comb begin
      next_state = state;
      case (state)
         lbc_pkg::ST_IDLE: begin
            if (grant_now)
               next_state = lbc_pkg::ST_GRANT;
            else if (take_now)
               next_state = lbc_pkg::ST_ADDR;
         end
         lbc_pkg::ST_ADDR: next_state = lbc_pkg::ST_STROBE;
         lbc_pkg::ST_STROBE: next_state = lbc_pkg::ST_WAIT;
         lbc_pkg::ST_WAIT: begin
            if (cycle_ok) // see RULE5
               next_state = lbc_pkg::ST_END;
         end
         lbc_pkg::ST_END: next_state = lbc_pkg::ST_IDLE;
         lbc_pkg::ST_GRANT: begin
            if (!hold_s) // see RULE14
               next_state = lbc_pkg::ST_IDLE;
         end
         default: next_state = lbc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst)
         state <= lbc_pkg::ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clock) begin
      if (rst)
         cur <= '0;
      else if (take_now)
         cur <= req;
   end

   // Boundary opens after a cycle marked last, closes on a new cycle
   always_ff @(posedge clock) begin
      if (rst)
         at_boundary <= 1'b1;
      else if (take_now)
         at_boundary <= 1'b0;
      else if (finish && cur.last)
         at_boundary <= 1'b1;
   end

   // Lock spans the locked instruction up to its boundary
   always_ff @(posedge clock) begin
      if (rst)
         lock_active <= 1'b0;
      else if (take_now && req.locked)
         lock_active <= 1'b1; // see RULE8
      else if (finish && cur.last)
         lock_active <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin values for the next cycle

   wire active = (next_state == lbc_pkg::ST_ADDR)
                 || (next_state == lbc_pkg::ST_STROBE)
                 || (next_state == lbc_pkg::ST_WAIT)
                 || (next_state == lbc_pkg::ST_END);
   wire strobing = (next_state == lbc_pkg::ST_STROBE)
                   || (next_state == lbc_pkg::ST_WAIT);
   lbc_pkg::request_type nxt;
   assign nxt = take_now ? req : cur;

   wire is_write = (nxt.kind == `KIND_WRITE);
   wire is_refresh = (nxt.kind == `KIND_REFRESH);
   // Refresh always uses the refresh lane code
   wire [1:0] lane = is_refresh ? `LANE_REFRESH : nxt.lane;

   lbc_pkg::bus_pins_type next_pins;
   always_comb begin
      next_pins.read_n = ~(strobing && !is_write); // see RULE3
      next_pins.write_n = ~(strobing && is_write); // see RULE4
      // Enable only while data really moves; refresh carries none
      next_pins.transceiver_enable_n =
         ~(strobing && !is_refresh); // see RULE6
      next_pins.transceiver_direction = (active && is_write) ?
         `DIR_TRANSMIT : `DIR_RECEIVE; // see RULE7
      next_pins.upper_byte_enable_n = active ?
         lane[`LANE_UPPER_BIT] : `STROBE_IDLE; // see RULE1
      next_pins.addr0 = active ? lane[`LANE_A0_BIT] : 1'b0; // see RULE1
      next_pins.refresh_indicator_n =
         ~(NARROW_BUS && active && is_refresh); // see RULE2
      next_pins.coproc_select_n =
         ~(!NARROW_BUS && active && nxt.coproc); // see RULE12
   end

   wire next_grant = (next_state == lbc_pkg::ST_GRANT);
   wire next_lock = (take_now && req.locked) || (lock_active
                    && !(finish && cur.last));

   always_ff @(posedge clock) begin
      if (rst) begin
         pins <= '1;
         pins_oe <= 1'b0;
         bus_grant_out <= 1'b0;
      end else begin
         pins <= next_pins;
         // Float the bus while the other master owns it
         pins_oe <= !next_grant; // see RULE11
         bus_grant_out <= next_grant; // see RULE11 see RULE14
      end
   end

   // Lock pin: undriven in reset so the pull keeps it high
   always_ff @(posedge clock) begin
      if (rst) begin
         lock_out <= 1'b1;
         lock_oe <= 1'b0; // see RULE9
      end else begin
         lock_out <= ~next_lock; // see RULE8
         lock_oe <= !next_grant;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core handshake

   always_ff @(posedge clock) begin
      if (rst) begin
         req_taken <= 1'b0;
         cycle_done <= 1'b0;
      end else begin
         req_taken <= take_now;
         cycle_done <= (state == lbc_pkg::ST_WAIT) && cycle_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Coprocessor exception

   always_ff @(posedge clock) begin
      if (rst) begin
         fault_irq <= 1'b0;
         fault_vector <= 8'h00;
      end else begin
         // Narrow variant has no error pin
         fault_irq <= numerics_start && !error_n_s
                      && !NARROW_BUS; // see RULE13
         fault_vector <= `FAULT_VECTOR; // see RULE13
      end
   end

endmodule

//--- tb/lbc_props.sv
`timescale 1ns/1ps
`include "lbc_cfg.svh"
module lbc_props #(
   parameter bit NARROW_BUS = 1'h0
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Core side
   input wire logic req_taken,
   input wire logic numerics_start,
   input wire logic fault_irq,
   input wire logic [7:0] fault_vector,
   // Pins
   input wire logic hold,
   input wire lbc_pkg::bus_pins_type pins,
   input wire logic pins_oe,
   input wire logic lock_out,
   input wire logic lock_oe,
   input wire logic bus_grant_out
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence strobe_on;
      !pins.read_n || !pins.write_n;
   endsequence
   sequence bus_back;
      !bus_grant_out && pins_oe;
   endsequence
   chk_single_strobe: assert property (
      pins.read_n || pins.write_n)
      else $error("read and write strobes both low");
   chk_enable_data: assert property (
      !pins.transceiver_enable_n |-> strobe_on)
      else $error("transceiver enabled with no transfer");
   chk_write_dir: assert property (
      !pins.write_n |-> pins.transceiver_direction == `DIR_TRANSMIT)
      else $error("write without transmit direction");
   chk_taken_strobe: assert property (
      req_taken |=> strobe_on)
      else $error("no strobe after request taken");
   chk_grant_floats: assert property (
      bus_grant_out |-> !pins_oe && !lock_oe)
      else $error("bus driven while granted");
   chk_lock_blocks: assert property (
      $rose(bus_grant_out) |-> $past(lock_out))
      else $error("grant while locked");
   chk_grant_cause: assert property (
      $rose(bus_grant_out) |-> $past(hold, 2))
      else $error("grant without hold");
   chk_grant_stays: assert property (
      bus_grant_out && hold |=> bus_grant_out)
      else $error("grant dropped while hold high");
   chk_grant_ends: assert property (
      $fell(hold) && bus_grant_out |-> ##[1:4] bus_back)
      else $error("grant not released after hold");
   chk_reset_lock: assert property (
      $fell(rst) |-> !lock_oe ##1 lock_oe)
      else $error("lock pin driven during reset");
   chk_fault_cause: assert property (
      fault_irq |-> $past(numerics_start) || $past(numerics_start, 2))
      else $error("fault without numerics start");
   chk_vector_fixed: assert property (
      !$past(rst) |-> fault_vector == `FAULT_VECTOR)
      else $error("wrong fault vector");
   chk_refresh_narrow: assert property (
      !pins.refresh_indicator_n |->
      NARROW_BUS && pins.upper_byte_enable_n && pins.addr0)
      else $error("refresh marked outside a narrow refresh cycle");
endmodule

bind local_bus_ctrl lbc_props #(.NARROW_BUS(NARROW_BUS)) props (
   .clock(clock), .rst(rst), .req_taken(req_taken),
   .numerics_start(numerics_start), .fault_irq(fault_irq),
   .fault_vector(fault_vector), .hold(hold), .pins(pins), .pins_oe(pins_oe),
   .lock_out(lock_out), .lock_oe(lock_oe), .bus_grant_out(bus_grant_out));

//--- tb/bus_responder.sv
`timescale 1ns/1ps
module bus_responder (
   // Clock
   input wire logic clock,
   // Bus side
   input wire lbc_pkg::bus_pins_type pins,
   input wire logic pins_oe,
   input wire logic stall,
   output logic ready
);
   // Ready falls between strobes so a stale level never ends the next cycle
   initial ready = 1'h0;
   always @(posedge clock) begin
      ready <= #2 pins_oe && !stall && !(pins.read_n && pins.write_n);
   end
endmodule

//--- tb/local_bus_control_signals_bench.sv
`timescale 1ns/1ps
`include "lbc_cfg.svh"
module local_bus_control_signals_bench;
   logic clock, rst, req_valid, req_taken, cycle_done, numerics_start;
   logic fault_irq, ready, hold, error_n, pins_oe, lock_in, lock_out;
   logic lock_oe, bus_grant_out, stall;
   logic [7:0] fault_vector;
   lbc_pkg::request_type req;
   lbc_pkg::bus_pins_type pins;
   lbc_pkg::bus_pins_type pins_narrow;
   logic fault_irq_narrow;
   int fail_count = 0;
   int check_count = 0;
   // Lock pin has a pull-up and nobody else drives it low
   assign lock_in = lock_oe ? lock_out : 1'h1;
   local_bus_ctrl #(.NARROW_BUS(1'h0)) dut (.clock(clock), .rst(rst),
      .req_valid(req_valid), .req(req), .req_taken(req_taken),
      .cycle_done(cycle_done), .numerics_start(numerics_start),
      .fault_irq(fault_irq), .fault_vector(fault_vector), .ready(ready),
      .hold(hold), .error_n(error_n), .pins(pins), .pins_oe(pins_oe),
      .lock_in(lock_in), .lock_out(lock_out), .lock_oe(lock_oe),
      .bus_grant_out(bus_grant_out));
   // Narrow variant shares every input; only refresh, select and the fault interrupt differ
   local_bus_ctrl #(.NARROW_BUS(1'h1)) dut_narrow (.clock(clock), .rst(rst),
      .req_valid(req_valid), .req(req), .req_taken(), .cycle_done(),
      .numerics_start(numerics_start), .fault_irq(fault_irq_narrow),
      .fault_vector(), .ready(ready), .hold(hold), .error_n(error_n),
      .pins(pins_narrow), .pins_oe(), .lock_in(lock_in), .lock_out(),
      .lock_oe(), .bus_grant_out());
   bus_responder far (.clock(clock), .pins(pins), .pins_oe(pins_oe),
      .stall(stall), .ready(ready));
   initial begin
      clock = 1'h0;
      forever #12.5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, exp, input string what);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick();
      @(posedge clock);
      #2;
   endtask
   task automatic wait_grant(input logic lvl);
      int n;
      n = 0;
      while (bus_grant_out !== lvl) begin
         tick();
         n++;
         if (n > 8) begin
            check(8'h0, 8'h1, "grant_timeout");
            print_verdict();
         end
      end
      check(8'(pins_oe), 8'(!lvl), "pins_oe");
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Stalled ready must hold the cycle open unless ready is ignored
   task automatic run_cycle(input lbc_pkg::request_type r, input logic st);
      logic [7:0] exp;
      logic [7:0] exp_narrow;
      lbc_pkg::lane_type ln;
      logic done;
      ln = (r.kind == `KIND_REFRESH) ? `LANE_REFRESH : r.lane;
      exp = {(r.kind == `KIND_WRITE) ? 2'h2 : 2'h1, r.kind == `KIND_REFRESH,
         r.kind == `KIND_WRITE, ln[`LANE_UPPER_BIT], ln[`LANE_A0_BIT], 1'h1,
         !r.coproc};
      // Narrow bus marks refresh on its own pin and has no select
      exp_narrow = {exp[7:2], r.kind != `KIND_REFRESH, 1'h1};
      stall = st;
      req = r;
      req_valid = 1'h1;
      done = 1'h0;
      for (int n = 0; req_taken !== 1'h1; n++) begin
         tick();
         if (n > 30) begin
            check(8'h0, 8'h1, "take_timeout");
            print_verdict();
         end
      end
      req_valid = 1'h0;
      for (int i = 0; i < 40; i++) begin
         if (i == 12) begin
            check(8'(done), 8'(r.ignore_ready | !st), "done_12");
            stall = 1'h0;
         end
         tick();
         if (pins_oe && !(pins.read_n && pins.write_n)) begin
            check(pins, exp, "pins");
            check(pins_narrow, exp_narrow, "pins_narrow");
         end
         done = done | (cycle_done === 1'h1);
      end
      check(8'(done), 8'h1, "cycle_done");
   endtask
   task automatic t_fault(input logic err);
      logic seen;
      error_n = err;
      repeat (4) tick();
      numerics_start = 1'h1;
      tick();
      numerics_start = 1'h0;
      seen = fault_irq;
      check(8'(fault_irq_narrow), 8'h0, "fault_irq_narrow");
      tick();
      seen = seen | fault_irq;
      check(8'(seen), 8'(!err), "fault_irq");
      check(fault_vector, 8'h10, "fault_vector");
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'h1;
      req_valid = 1'h0;
      req = '0;
      numerics_start = 1'h0;
      hold = 1'h0;
      error_n = 1'h1;
      stall = 1'h0;
      repeat (20) tick();
      check(pins, 8'hff, "reset_pins");
      check({lock_oe, pins_oe, bus_grant_out}, 8'h0, "reset_oe");
      rst = 1'h0;
      tick();
      hold = 1'h1;
      wait_grant(1'h1);
      repeat (10) tick();
      check(8'(bus_grant_out), 8'h1, "grant_kept");
      hold = 1'h0;
      wait_grant(1'h0);
      for (int k = 0; k < 3; k++) begin
         for (int l = 0; l < 3; l++) begin
            run_cycle({k[1:0], l[1:0], l == 1 && k < 2, 3'h2},
               1'h0);
         end
      end
      run_cycle({`KIND_READ, `LANE_WORD, 4'h2}, 1'h1);
      run_cycle({`KIND_WRITE, `LANE_ODD, 4'h3}, 1'h1);
      run_cycle({`KIND_READ, `LANE_WORD, 4'h4}, 1'h0);
      hold = 1'h1;
      repeat (8) tick();
      check({bus_grant_out, lock_out}, 8'h0, "no_grant");
      run_cycle({`KIND_WRITE, `LANE_EVEN, 4'h6}, 1'h0);
      wait_grant(1'h1);
      hold = 1'h0;
      wait_grant(1'h0);
      t_fault(1'h0);
      t_fault(1'h1);
      print_verdict();
   end
endmodule
